// ==== core/msrp_consts.svh ====
// Purpose: offsets, field positions, reset values and limits of the result packer
// Assumes: included by the packer files by bare name
// Notes:   quarter-unit vector limits are the printed ranges times four
`ifndef MSRP_CONSTS_SVH
`define MSRP_CONSTS_SVH

// register offsets
`define MSRP_CTRL_OFS        8'h00
`define MSRP_STATUS_OFS      8'h04
`define MSRP_COUNT_OFS       8'h08
// control fields
`define MSRP_CTRL_INTER_EN   0
`define MSRP_CTRL_VFMT_REQ   1
`define MSRP_CTRL_CODEC_SEL  2
`define MSRP_CTRL_REP_REQ    3
`define MSRP_CTRL_UNPACK_EN  4
`define MSRP_CTRL_SEL_LO     8
`define MSRP_CTRL_RESET      32'h0000_0101
// first word fields
`define MSRP_SKIP_BIT        2
`define MSRP_MODE_LO         0
// cost word fields
`define MSRP_COST_HI_LO      16
`define MSRP_COST_LO_LO      0
// vector limits in quarter units
`define MSRP_Y_MIN           16'hF800
`define MSRP_Y_MAX           16'h07FF
`define MSRP_X_MIN           16'hE000
`define MSRP_X_MAX           16'h1FFF
// message shape
`define MSRP_LAST_PHASE      3'h5
`define MSRP_VEC_PER_PHASE   4

`endif

// ==== core/msrp_pkg.sv ====
// Purpose: shared types of the motion-search result packer
// Assumes: nothing
// Notes:   state codes are one-hot
package msrp_pkg;
  typedef enum logic [1:0] {
    MSRP_IDLE = 2'b01,
    MSRP_SEND = 2'b10
  } msrp_state_type;
  typedef logic [4:0]   msrp_bind_type;
  typedef logic [255:0] msrp_phase_type;
endpackage

// ==== core/msrp_ref_mux.sv ====
// Purpose: reference-index slot muxes for four sub-blocks of one list pair
// Assumes: select is one-hot; replicated-active comes from same clock logic
// Notes:   purely combinational
`timescale 1ns/1ps
module msrp_ref_mux (
  input  wire logic [3:0]  rep_select_i,     // one-hot replication select
  input  wire logic        rep_active_i,     // replicated form active
  input  wire logic [19:0] fwd_binding_i,    // forward bindings, sub-block 0 low
  input  wire logic [19:0] bkd_binding_i,    // backward bindings, sub-block 0 low
  output logic      [19:0] list0_slot_o,     // list-0 sub-block slots
  output logic      [19:0] list1_slot_o      // list-1 sub-block slots
);
  import msrp_pkg::*;

  // pick the four slots of one list from its four bindings
  function automatic logic [19:0] pick(input logic [19:0] b, input logic [3:0] sel,
                                       input logic rep);
    logic [4:0] b0;
    logic [4:0] b1;
    logic [4:0] b2;
    logic [4:0] adj1;
    b0 = b[4:0];
    b1 = b[9:5];
    b2 = b[14:10];
    adj1 = rep ? b2 : b1;                              // [R18]
    case (sel)
      4'h1:    pick = b;                               // [R14]
      4'h2:    pick = {b1, b0, b1, b0};                // [R15]
      4'h4:    pick = {adj1, adj1, b0, b0};            // [R16] [R18]
      4'h8:    pick = {b0, b0, b0, b0};                // [R17]
      default: pick = b;                               // [R19]
    endcase
  endfunction

  // both lists share the same selection
  assign list0_slot_o = pick(fwd_binding_i, rep_select_i, rep_active_i);
  assign list1_slot_o = pick(bkd_binding_i, rep_select_i, rep_active_i);
endmodule

// ==== core/msrp_packer.sv ====
// Purpose: assemble the six-phase result message of the motion search unit
// Assumes: result inputs come from logic on clk_sys_i; kernel side gives ready
// Notes:   one message at a time; a start while busy is ignored
//
// Notes on behaviour
// [R1] skip-win flag in bit 2, intra ignored
// [R2] inter mode bits 1:0 when inter enabled
// [R3] vector y high, x low; ref1 above ref0
// [R4] vertical limited to -512.00..511.75 quarters
// [R5] horizontal limited to -2048.00..2047.75 quarters
// [R6] sixteen vectors per reference, interleaved words
// [R7] phases one to four carry vectors in order
// [R8] phase five upper words carry costs 15..2
// [R9] lowest cost word: 29:16 and 13:0
// [R10] unchosen sub-shape cost is zero
// [R11] duplicated vector slot cost is zero
// [R12] format-active ANDed, ORed into unpack enable
// [R13] replicated-active is request AND codec
// [R14] select 0001 gives own binding
// [R15] select 0010 repeats sub-blocks 0 and 1
// [R16] select 0100 uses adjusted bindings
// [R17] select 1000 copies sub-block 0 everywhere
// [R18] adjusted binding 1 follows replicated form
// [R19] other selects behave like 0001
`timescale 1ns/1ps
`include "msrp_consts.svh"
module msrp_packer #(
  parameter int NUM_VEC = 16                         // vectors per reference
) (
  input  wire logic                 clk_sys_i,        // core clock, 100 MHz
  input  wire logic                 reset_i,          // synchronous reset, high
  // register port
  input  wire logic [7:0]           reg_addr_i,       // byte address
  input  wire logic [31:0]          reg_wdata_i,      // write data
  input  wire logic                 reg_write_i,      // write strobe
  input  wire logic                 reg_read_i,       // read strobe
  output logic      [31:0]          reg_rdata_o,      // read data, next cycle
  // search result
  input  wire logic                 res_start_i,      // result valid pulse
  output logic                      res_ready_o,      // packer idle
  input  wire logic                 skip_win_flag_i,  // a skip centre won
  input  wire logic                 intra_block_flag_i, // intra winner, not used
  input  wire logic [1:0]           inter_partition_mode_i, // winning partition
  input  wire logic [NUM_VEC*32-1:0] ref0_motion_vector_i, // {y,x} per vector
  input  wire logic [NUM_VEC*32-1:0] ref1_motion_vector_i, // {y,x} per vector
  input  wire logic [NUM_VEC*14-1:0] per_vector_cost_i,   // raw costs
  input  wire logic [NUM_VEC-1:0]   shape_chosen_i,   // sub-shape chosen per slot
  input  wire logic [NUM_VEC-1:0]   vec_duplicated_i, // slot made by duplication
  // bindings
  input  wire logic [19:0]          forward_subblock_binding_i,  // fwd, sub-block 0 low
  input  wire logic [19:0]          backward_subblock_binding_i, // bkd, sub-block 0 low
  output logic      [19:0]          list0_subblock_ref_slot_o,   // list-0 slots
  output logic      [19:0]          list1_subblock_ref_slot_o,   // list-1 slots
  output logic                      vector_unpack_enable_o,      // effective unpack
  // message to the kernel
  output logic                      msg_valid_o,      // phase valid
  input  wire logic                 msg_ready_i,      // kernel takes phase
  output logic      [2:0]           msg_phase_o,      // phase index 0..5
  output logic                      msg_last_o,       // last phase
  output msrp_pkg::msrp_phase_type  msg_data_o        // eight words, word 0 low
);
  import msrp_pkg::*;

  msrp_state_type state_r;
  logic [31:0]    ctrl_r;
  logic [31:0]    count_r;
  logic [31:0]    rdata_r;
  logic [2:0]     phase_r;
  msrp_phase_type data_r;
  logic           skip_r;
  logic [1:0]     mode_r;
  logic [31:0]    vec0_r [NUM_VEC];
  logic [31:0]    vec1_r [NUM_VEC];
  logic [13:0]    cost_r [NUM_VEC];
  logic           inter_en;
  logic           vec_fmt_active;
  logic           rep_active;
  logic           accept;
  logic           advance;
  logic [2:0]     phase_nxt;

  // clamp one signed component between two limits
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) begin
      clamp = lo;
    end else if ($signed(v) > $signed(hi)) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // limit a {y,x} vector word to the hardware range
  function automatic logic [31:0] limit_vec(input logic [31:0] v);
    limit_vec = {clamp(v[31:16], `MSRP_Y_MIN, `MSRP_Y_MAX),   // [R4] [R3]
                 clamp(v[15:0], `MSRP_X_MIN, `MSRP_X_MAX)};   // [R5] [R3]
  endfunction

  // control bits and derived enables
  assign inter_en       = ctrl_r[`MSRP_CTRL_INTER_EN];
  assign vec_fmt_active = ctrl_r[`MSRP_CTRL_VFMT_REQ] & ctrl_r[`MSRP_CTRL_CODEC_SEL]; // [R12]
  assign rep_active     = ctrl_r[`MSRP_CTRL_REP_REQ] & ctrl_r[`MSRP_CTRL_CODEC_SEL];  // [R13]
  assign vector_unpack_enable_o = ctrl_r[`MSRP_CTRL_UNPACK_EN] | vec_fmt_active;      // [R12]

  // reference slot muxes
  msrp_ref_mux u_ref_mux (
    .rep_select_i  (ctrl_r[`MSRP_CTRL_SEL_LO +: 4]),
    .rep_active_i  (rep_active),
    .fwd_binding_i (forward_subblock_binding_i),
    .bkd_binding_i (backward_subblock_binding_i),
    .list0_slot_o  (list0_subblock_ref_slot_o),
    .list1_slot_o  (list1_subblock_ref_slot_o)
  );

  // handshake terms
  assign res_ready_o = (state_r == MSRP_IDLE);
  assign accept      = res_ready_o & res_start_i;
  assign advance     = (state_r == MSRP_SEND) & msg_ready_i;
  assign phase_nxt   = phase_r + 3'h1;
  assign msg_valid_o = (state_r == MSRP_SEND);
  assign msg_phase_o = phase_r;
  assign msg_last_o  = msg_valid_o & (phase_r == `MSRP_LAST_PHASE);
  assign msg_data_o  = data_r;
  assign reg_rdata_o = rdata_r;

  // build one phase of the message from the latched result
  function automatic msrp_phase_type build(input logic [2:0] ph, input logic sk,
                                           input logic [1:0] md);
    msrp_phase_type p;
    int             base;
    p = '0;
    base = 0;
    if (ph == 3'h0) begin
      p[`MSRP_SKIP_BIT] = sk;                               // [R1]
      p[`MSRP_MODE_LO +: 2] = md;                           // [R2]
    end else if (ph <= 3'h4) begin
      base = (int'(ph) - 1) * `MSRP_VEC_PER_PHASE;          // [R7]
      for (int k = 0; k < `MSRP_VEC_PER_PHASE; k++) begin
        p[64*k +: 32]      = vec0_r[base + k];              // [R6] [R3]
        p[64*k + 32 +: 32] = vec1_r[base + k];              // [R6] [R3]
      end
    end else begin
      for (int w = 0; w < NUM_VEC / 2; w++) begin
        p[32*w + `MSRP_COST_LO_LO +: 14] = cost_r[2*w];     // [R8] [R9]
        p[32*w + `MSRP_COST_HI_LO +: 14] = cost_r[2*w + 1]; // [R8] [R9]
      end
    end
    return p;
  endfunction

  // message state
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= MSRP_IDLE;
    end else begin
      case (state_r)
        MSRP_IDLE: begin
          if (accept) begin
            state_r <= MSRP_SEND;
          end
        end
        MSRP_SEND: begin
          if (advance && phase_r == `MSRP_LAST_PHASE) begin
            state_r <= MSRP_IDLE;
          end
        end
        default: state_r <= MSRP_IDLE;
      endcase
    end
  end

  // phase counter
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase_r <= 3'h0;
    end else if (accept) begin
      phase_r <= 3'h0;
    end else if (advance) begin
      phase_r <= (phase_r == `MSRP_LAST_PHASE) ? 3'h0 : phase_nxt;
    end
  end

  // first word fields, latched at start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      skip_r <= 1'b0;
      mode_r <= 2'h0;
    end else if (accept) begin
      skip_r <= skip_win_flag_i;                                    // [R1]
      mode_r <= inter_en ? inter_partition_mode_i : 2'h0;           // [R2]
    end
  end

  // vectors and costs, latched at start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_VEC; i++) begin
        vec0_r[i] <= 32'h0;
        vec1_r[i] <= 32'h0;
        cost_r[i] <= 14'h0;
      end
    end else if (accept) begin
      for (int i = 0; i < NUM_VEC; i++) begin
        vec0_r[i] <= limit_vec(ref0_motion_vector_i[32*i +: 32]);  // [R4] [R5]
        vec1_r[i] <= limit_vec(ref1_motion_vector_i[32*i +: 32]);  // [R4] [R5]
        if (!shape_chosen_i[i] || vec_duplicated_i[i]) begin
          cost_r[i] <= 14'h0;                                       // [R10] [R11]
        end else begin
          cost_r[i] <= per_vector_cost_i[14*i +: 14];
        end
      end
    end
  end

  // phase data register: phase 0 is loaded from the inputs on the accept edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_r <= '0;
    end else if (accept) begin
      data_r <= '0;
      data_r[`MSRP_SKIP_BIT] <= skip_win_flag_i;                    // [R1]
      data_r[`MSRP_MODE_LO +: 2] <= inter_en ? inter_partition_mode_i : 2'h0; // [R2]
    end else if (advance && phase_r != `MSRP_LAST_PHASE) begin
      data_r <= build(phase_nxt, skip_r, mode_r);                   // [R7]
    end
  end

  // control register writes
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_r <= `MSRP_CTRL_RESET;
    end else if (reg_write_i && reg_addr_i == `MSRP_CTRL_OFS) begin
      ctrl_r <= {20'h0, reg_wdata_i[11:8], 3'h0, reg_wdata_i[4:0]};
    end
  end

  // completed message count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_r <= 32'h0;
    end else if (reg_write_i && reg_addr_i == `MSRP_COUNT_OFS) begin
      count_r <= 32'h0;
    end else if (advance && phase_r == `MSRP_LAST_PHASE) begin
      count_r <= count_r + 32'h1;
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `MSRP_CTRL_OFS:   rdata_r <= ctrl_r;
        `MSRP_STATUS_OFS: rdata_r <= {25'h0, vector_unpack_enable_o, rep_active,
                                      vec_fmt_active, phase_r, msg_valid_o};
        `MSRP_COUNT_OFS:  rdata_r <= count_r;
        default:          rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end
endmodule

// ==== tb/msrp_checker.sv ====
// Purpose: port checks of the result packer
// Assumes: one clock, sync reset
// Notes:   select is internal, so slot 0 is checked
`timescale 1ns/1ps
module msrp_checker (
  input wire logic        clk_sys_i,       // clock
  input wire logic        reset_i,         // reset
  input wire logic        res_start_i,     // start
  input wire logic        res_ready_o,     // idle
  input wire logic        skip_win_flag_i, // skip
  input wire logic        msg_valid_o,     // valid
  input wire logic        msg_ready_i,     // take
  input wire logic [2:0]  msg_phase_o,     // phase
  input wire logic        msg_last_o,      // last
  input wire msrp_pkg::msrp_phase_type msg_data_o, // data
  input wire logic [19:0] forward_subblock_binding_i,  // fwd
  input wire logic [19:0] backward_subblock_binding_i, // bkd
  input wire logic [19:0] list0_subblock_ref_slot_o,   // l0
  input wire logic [19:0] list1_subblock_ref_slot_o    // l1
);
  import msrp_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // framing, phase order and field checks
  start_phase_a: assert property (res_start_i && res_ready_o |=>
    msg_valid_o && msg_phase_o == 3'h0 && !res_ready_o) else $error("bad start");
  skip_flag_a: assert property (res_start_i && res_ready_o |=>
    msg_data_o[2] == $past(skip_win_flag_i)) else $error("bad skip");
  phase_step_a: assert property (msg_valid_o && msg_ready_i && !msg_last_o |=>
    msg_valid_o && msg_phase_o == $past(msg_phase_o) + 3'h1) else $error("bad step");
  msg_end_a: assert property (msg_last_o && msg_ready_i |=>
    !msg_valid_o && res_ready_o) else $error("bad end");
  phase_hold_a: assert property (msg_valid_o && !msg_ready_i |=>
    msg_valid_o && $stable(msg_data_o) && $stable(msg_phase_o)) else $error("bad hold");
  last_flag_a: assert property (msg_last_o == (msg_valid_o && msg_phase_o == 3'h5))
    else $error("bad last");
  cost_pad_a: assert property (msg_valid_o && msg_phase_o == 3'h5 |->
    msg_data_o[31:30] == 2'h0 && msg_data_o[15:14] == 2'h0) else $error("bad pad");
  slot_zero_a: assert property (
    list0_subblock_ref_slot_o[4:0] == forward_subblock_binding_i[4:0] &&
    list1_subblock_ref_slot_o[4:0] == backward_subblock_binding_i[4:0]) else $error("bad slot");
  // main scenarios
  cover property (msg_last_o && msg_ready_i);
  cover property (msg_valid_o && !msg_ready_i);
  cover property (res_start_i && !res_ready_o);
endmodule
bind msrp_packer msrp_checker u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .res_start_i(res_start_i), .res_ready_o(res_ready_o), .skip_win_flag_i(skip_win_flag_i),
  .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_phase_o(msg_phase_o),
  .msg_last_o(msg_last_o), .msg_data_o(msg_data_o),
  .forward_subblock_binding_i(forward_subblock_binding_i),
  .backward_subblock_binding_i(backward_subblock_binding_i),
  .list0_subblock_ref_slot_o(list0_subblock_ref_slot_o),
  .list1_subblock_ref_slot_o(list1_subblock_ref_slot_o));

// ==== tb/msrp_kernel_model.sv ====
// Purpose: kernel thread taking result phases
// Assumes: phases are offered as a level
// Notes:   slow mode takes about one cycle in four
`timescale 1ns/1ps
module msrp_kernel_model (
  input  wire logic clk_sys_i,  // clock
  input  wire logic reset_i,    // reset
  input  wire logic slow_i,     // stall often
  output logic      msg_ready_o // take phase
);
  integer seed = 32'h9828c852;
  // accept pattern, prompt or stalling
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      msg_ready_o <= 1'b0;
    end else begin
      msg_ready_o <= !slow_i || (($random(seed) & 3) == 0);
    end
  end
endmodule

// ==== tb/msrp_packer_tb_top.sv ====
// Purpose: self-checking bench of the result packer
// Assumes: kernel model drives the phase accept
// Notes:   drivers queue expectations, the monitor pops them
`timescale 1ns/1ps
module msrp_packer_tb_top;
  import msrp_pkg::*;
  logic clk, rst, wr_i, rd_i, start_i, skip_i, intra_i, slow, rd_d, ready_o, unp_o, val_o, take;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0] mode_i;
  logic [2:0] ph_o;
  logic [511:0] mv0_i, mv1_i;
  logic [223:0] cost_i;
  logic [15:0] cho_i, dup_i;
  logic [19:0] fwd_i, bkd_i, l0_o, l1_o;
  msrp_phase_type data_o;
  logic [31:0] rq[$];
  logic [255:0] mq[$];
  logic [3:0] sels[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  integer seed = 32'h9828c852;
  int errors = 0;
  int compares = 0;
  msrp_packer DUT (.clk_sys_i(clk), .reset_i(rst), .reg_addr_i(addr_i), .reg_wdata_i(wdata_i),
    .reg_write_i(wr_i), .reg_read_i(rd_i), .reg_rdata_o(rdata_o), .res_start_i(start_i),
    .res_ready_o(ready_o), .skip_win_flag_i(skip_i), .intra_block_flag_i(intra_i),
    .inter_partition_mode_i(mode_i), .ref0_motion_vector_i(mv0_i),
    .ref1_motion_vector_i(mv1_i), .per_vector_cost_i(cost_i), .shape_chosen_i(cho_i),
    .vec_duplicated_i(dup_i), .forward_subblock_binding_i(fwd_i),
    .backward_subblock_binding_i(bkd_i), .list0_subblock_ref_slot_o(l0_o),
    .list1_subblock_ref_slot_o(l1_o), .vector_unpack_enable_o(unp_o), .msg_valid_o(val_o),
    .msg_ready_i(take), .msg_phase_o(ph_o), .msg_last_o(), .msg_data_o(data_o));
  msrp_kernel_model u_kern (.clk_sys_i(clk), .reset_i(rst), .slow_i(slow), .msg_ready_o(take));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [255:0] s, input logic [255:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr_i <= a;
    rd_i <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd_i <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      if (ready_o === 1'b1) return;
    end
    errors++;
    finish_test();
  endtask
  // clamp to the vertical and horizontal quarter-unit ranges
  function automatic logic [31:0] clv(input logic [31:0] v);
    logic signed [15:0] y;
    logic signed [15:0] x;
    y = v[31:16];
    x = v[15:0];
    y = (y < -2048) ? -16'sd2048 : (y > 2047) ? 16'sd2047 : y;
    x = (x < -8192) ? -16'sd8192 : (x > 8191) ? 16'sd8191 : x;
    return {y, x};
  endfunction
  function automatic logic [19:0] slots(input logic [19:0] b, input logic [3:0] s, input logic r);
    logic [4:0] a1;
    a1 = r ? b[14:10] : b[9:5];
    case (s)
      4'h2: return {b[9:0], b[9:0]};
      4'h4: return {a1, a1, b[4:0], b[4:0]};
      4'h8: return {4{b[4:0]}};
      default: return b;
    endcase
  endfunction
  // one message; start held two edges so the second is refused while busy
  task automatic send(input logic inter);
    logic [1023:0] a;
    logic [223:0] c;
    logic [255:0] p;
    logic [31:0] v;
    logic [31:0] u;
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      a[32*i+:32] = v[0] ? {{5{v[26]}}, v[26:16], {3{v[12]}}, v[12:0]} : v;
    end
    c = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed), $random(seed)};
    v = $random(seed);
    u = $random(seed);
    p = '0;
    p[2:0] = {v[2], inter ? v[1:0] : 2'h0};
    mq.push_back(p);
    for (int k = 0; k < 4; k++) begin
      for (int w = 0; w < 8; w++)
        p[32*w+:32] = clv(a[512*(w%2)+32*(4*k+w/2)+:32]);
      mq.push_back(p);
    end
    for (int i = 0; i < 16; i++)
      p[16*i+:16] = {2'h0, (v[16+i] && !u[i]) ? c[14*i+:14] : 14'h0};
    mq.push_back(p);
    wait_idle();
    {mv1_i, mv0_i, cost_i, cho_i, dup_i} <= {a, c, v[31:16], u[15:0]};
    {skip_i, mode_i, intra_i, start_i} <= {v[2:0], u[20], 1'b1};
    repeat (2) @(posedge clk);
    start_i <= 1'b0;
  endtask
  // monitor pops the oldest note as each result shows
  always @(posedge clk) begin
    if (rd_d) chk(rdata_o, rq.pop_front());
    if (val_o && take) chk(data_o, mq.pop_front());
    rd_d <= rd_i;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic vf;
    {wr_i, rd_i, start_i, skip_i, intra_i, slow, rd_d, addr_i, wdata_i, mode_i} = '0;
    {mv0_i, mv1_i, cost_i, cho_i, dup_i, fwd_i, bkd_i} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0101);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      v = $random(seed);
      w = $random(seed);
      vf = v[1] && (i >= 5 || v[2]);
      wr(8'h00, {20'h0, sels[i%5], 3'h0, v[4], i >= 5, i >= 5 || v[2], v[1], 1'b1});
      fwd_i <= w[19:0];
      bkd_i <= w[31:12];
      @(posedge clk);
      #1;
      chk(l0_o, slots(w[19:0], sels[i%5], i >= 5));
      chk(l1_o, slots(w[31:12], sels[i%5], i >= 5));
      chk(unp_o, v[4] || vf);
      rd(8'h04, {25'h0, v[4] || vf, i >= 5, vf, 4'h0});
    end
    $display("test select done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m == 2 ? 32'h0000_0100 : 32'h0000_0101);
      slow <= m[0];
      send(m != 2);
      $display("test message %0d done", m);
    end
    wait_idle();
    rd(8'h08, 32'h4);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    repeat (2) @(posedge clk);
    $display("test count done");
    finish_test();
  end
endmodule
